// ### hw/smat_pkg.sv
// Shared constants, enumerations and carriers of the serial master address translator.
// Assumes a single 250 MHz clock domain and one serial framer that moves the queries onto the line.
//
// How it works
// - Fixed and ASCII modes use standard translations only
// - Configurable mode uses selected opcodes and offset
// - Offset is any 16-bit value, used as such
// - Offset applies only to configurable master translations
// - Register opcodes: address equals index plus offset
// - Fixed-translation mode always uses zero offset
// - Slave-side translation forms index with zero offset
// - Coil start is ((index+offset-1)*16)+1
// - Each register maps to sixteen aligned coils
// - No valid reply: wait timeout, then resend
// - At most two resends, three transmissions total
// - Always-on mode keeps transmitter enabled, full duplex
// - CTS-gated mode: transmitter enable follows CTS
// - Two-wire mode: follows CTS, receiver off transmitting
// - Cts_gated_driver_mode line: multidrop off, full duplex
// - Two-wire line: multidrop on, half duplex
// - Remote index must lie within 1..8192
// - Full-mask masked write becomes opcode 16 outside configurable mode
// - Untranslatable requests ride opcode 17, param 01
package smat_pkg;

	// ==========================================================
	// Timing.
	localparam int unsigned CLK_PERIOD_NS = 4; // Period of clk_sys.
	localparam int unsigned TICK_NS = 1000; // One retry timeout unit is a microsecond.
	localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS; // Cycles per timeout unit.
	localparam int unsigned TICK_CNT_W = 8; // Width of the tick prescaler.
	localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);
	localparam logic [1:0] MAX_RETRIES = 2'h2; // Resends after the first transmission.

	// ==========================================================
	// Address translation.
	localparam logic [15:0] INDEX_MIN = 16'h0001; // Lowest legal remote index.
	localparam logic [15:0] INDEX_MAX = 16'h2000; // Highest legal remote index, 8192.
	localparam logic [15:0] FULL_MASK = 16'hffff; // Masked write that touches every bit.
	localparam logic [15:0] ZERO_OFFSET = 16'h0000; // Offset seen outside configurable mode.
	localparam int unsigned COIL_SHIFT = 4; // Sixteen coils per register.
	localparam int unsigned FIFO_DEPTH = 16; // Requests buffered ahead of the translator.

	// ==========================================================
	// Serial opcodes and encapsulation parameters.
	localparam logic [7:0] OP_READ_COILS = 8'h01;
	localparam logic [7:0] OP_READ_HOLD = 8'h03;
	localparam logic [7:0] OP_READ_INPUT = 8'h04;
	localparam logic [7:0] OP_WRITE_COIL = 8'h05;
	localparam logic [7:0] OP_WRITE_REG = 8'h06;
	localparam logic [7:0] OP_WRITE_COILS = 8'h0f;
	localparam logic [7:0] OP_WRITE_REGS = 8'h10;
	localparam logic [7:0] OP_ENCAP = 8'h11;
	localparam logic [7:0] OP_MASK_WRITE = 8'h16;
	localparam logic [7:0] ENCAP_QUERY_PARAM = 8'h01;
	localparam logic [7:0] ENCAP_REPLY_PARAM = 8'h02;
	localparam logic [7:0] NO_PARAM = 8'h00;

	// ==========================================================
	// Enumerations and carriers.
	typedef enum logic [1:0] {SMAT_PM_FIXED, SMAT_PM_ASCII, SMAT_PM_CONFIG, SMAT_PM_SLAVE} smat_port_mode_t;
	typedef enum logic [1:0] {SMAT_DRV_ALWAYS_ON, SMAT_DRV_CTS_GATED, SMAT_DRV_TWO_WIRE} smat_drv_mode_t;
	typedef enum logic [1:0] {SMAT_REQ_READ, SMAT_REQ_WRITE, SMAT_REQ_MASKED, SMAT_REQ_OTHER} smat_req_kind_t;

	// Request from the network router.
	typedef struct packed {
		smat_req_kind_t kind;
		logic [15:0] index;
		logic [7:0] count;
		logic [15:0] mask;
		logic [7:0] tag;
	} smat_req_t;

	// Query handed to the serial framer.
	typedef struct packed {
		logic [7:0] opcode;
		logic [15:0] address;
		logic [15:0] count;
		logic [15:0] mask;
		logic [7:0] param;
		logic [7:0] tag;
	} smat_query_t;

	// Reply reported by the serial framer.
	typedef struct packed {
		logic [7:0] tag;
		logic [7:0] param;
		logic crc_ok;
	} smat_reply_t;

	// Completion returned to the originator.
	typedef struct packed {
		logic [7:0] tag;
		logic error;
		logic [1:0] retries;
	} smat_done_t;

endpackage : smat_pkg

// ### hw/smat_fifo.sv
// Synchronous request FIFO with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset already synchronised.
`timescale 1ns/1ps
`default_nettype none
module smat_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed.
	logic [AW-1:0] wr_ptr; // Next slot to fill.
	logic [AW-1:0] rd_ptr; // Oldest slot.
	logic [CW-1:0] count; // Words held.
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// The flags derive from a registered count so both stay honest under simultaneous push and pop.
	assign in_ready = (count != FULL_COUNT);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	// ==========================================================
	// Pointers and occupancy.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
			rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
			count <= CW'(count + CW'(push) - CW'(pop));
		end
	end

	// Storage write.
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule : smat_fifo
`default_nettype wire

// ### hw/smat_driver.sv
// Line driver control: transmitter and receiver enables plus the matching port options.
// Assumes cts and the framer's transmitting flag are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module smat_driver
	import smat_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire smat_drv_mode_t drv_mode,
	input wire logic cts,
	input wire logic transmitting,
	output logic tx_enable,
	output logic rx_enable,
	output logic opt_multidrop,
	output logic opt_full_duplex
);
	// ==========================================================
	// Decode of the wiring mode.
	logic next_tx;
	logic next_rx;
	always_comb begin
		next_tx = 1'b1;
		next_rx = 1'b1;
		case (drv_mode)
			SMAT_DRV_ALWAYS_ON: begin
				next_tx = 1'b1;
			end
			SMAT_DRV_CTS_GATED: begin
				next_tx = cts;
			end
			SMAT_DRV_TWO_WIRE: begin
				next_tx = cts;
				next_rx = !(cts || transmitting);
			end
			// An undefined code releases the line; the safe choice on a shared bus.
			default: begin
				next_tx = 1'b0;
			end
		endcase
	end

	// Registered so the pins never glitch while the mode changes.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_enable <= 1'b0;
			rx_enable <= 1'b0;
			opt_multidrop <= 1'b0;
			opt_full_duplex <= 1'b0;
		end else begin
			tx_enable <= next_tx;
			rx_enable <= next_rx;
			opt_multidrop <= (drv_mode == SMAT_DRV_TWO_WIRE);
			opt_full_duplex <= (drv_mode != SMAT_DRV_TWO_WIRE);
		end
	end
endmodule : smat_driver
`default_nettype wire

// ### hw/smat_translator.sv
// Serial master translator: buffers network requests, translates them to serial queries,
// retries on silence and reports completion; also forms slave-side indices and drives the line enables.
// Assumes a serial framer outside that sends each query, reports replies by tag and flags transmission.
`timescale 1ns/1ps
`default_nettype none
module smat_translator
	import smat_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire smat_port_mode_t port_mode,
	input wire smat_drv_mode_t drv_mode,
	input wire logic [7:0] cfg_read_opcode,
	input wire logic [7:0] cfg_write_opcode,
	input wire logic [15:0] reg_offset,
	input wire logic [15:0] retry_timeout,
	input wire logic req_valid,
	output logic req_ready,
	input wire smat_req_t req,
	output logic query_valid,
	input wire logic query_ready,
	output smat_query_t query,
	input wire logic reply_valid,
	input wire smat_reply_t reply,
	output logic done_valid,
	output smat_done_t done,
	input wire logic slave_valid,
	input wire logic [15:0] slave_addr,
	output logic slave_index_valid,
	output logic [15:0] slave_index,
	input wire logic cts,
	input wire logic transmitting,
	output logic tx_enable,
	output logic rx_enable,
	output logic opt_multidrop,
	output logic opt_full_duplex
);
	// ==========================================================
	// Reset release through two flip-flops.
	logic rst_meta; // First stage, read only by the second.
	logic rst_n; // Synchronised reset used everywhere else.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ==========================================================
	// Request buffer.
	logic head_valid; // A request waits at the FIFO head.
	logic head_pop; // Translator takes the head.
	smat_req_t head; // Oldest buffered request.
	logic fifo_in_ready; // Room in the buffer.
	logic [4:0] fill; // Mirror of the buffer occupancy.
	wire [4:0] next_fill = 5'(fill + 5'(req_valid && req_ready) - 5'(head_pop));

	// The ready port must come from a flop, so it is registered from the predicted fill rather than the FIFO's room;
	// fifo_in_ready goes unread and the buffer accepts all FIFO_DEPTH requests before refusing.
	smat_fifo #(.WIDTH($bits(smat_req_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(req_valid && req_ready),
		.in_ready(fifo_in_ready),
		.in_data(req),
		.out_valid(head_valid),
		.out_ready(head_pop),
		.out_data(head)
	);

	// ==========================================================
	// Translation of the head request, all combinational.
	wire is_config = (port_mode == SMAT_PM_CONFIG);
	wire [15:0] offset_eff = is_config ? reg_offset : ZERO_OFFSET;
	wire [15:0] reg_sum = 16'(head.index + offset_eff);
	wire [15:0] coil_start = 16'({16'(reg_sum - 16'h0001), 4'h0} + 20'h00001);
	wire index_ok = (head.index >= INDEX_MIN) && (head.index <= INDEX_MAX);
	wire full_mask = (head.mask == FULL_MASK);

	// Opcode choice per mode and request kind.
	logic [7:0] xl_op;
	always_comb begin
		xl_op = OP_ENCAP;
		case (head.kind)
			SMAT_REQ_READ: begin
				xl_op = is_config ? cfg_read_opcode : OP_READ_HOLD;
			end
			SMAT_REQ_WRITE: begin
				xl_op = is_config ? cfg_write_opcode : OP_WRITE_REGS;
			end
			SMAT_REQ_MASKED: begin
				if (full_mask) begin
					xl_op = is_config ? cfg_write_opcode : OP_WRITE_REGS;
				end else if (head.count == 8'h01 && !is_config) begin
					xl_op = OP_MASK_WRITE;
				end else begin
					xl_op = OP_ENCAP;
				end
			end
			default: begin
				xl_op = OP_ENCAP;
			end
		endcase
	end

	wire is_coil_op = (xl_op == OP_READ_COILS) || (xl_op == OP_WRITE_COIL) || (xl_op == OP_WRITE_COILS);
	wire is_reg_op = !is_coil_op && (xl_op != OP_ENCAP);
	// register address is index plus offset.
	wire [15:0] xl_addr = is_coil_op ? coil_start : reg_sum;
	wire [15:0] xl_count = is_coil_op ? 16'({head.count, 4'h0}) : {8'h00, head.count};
	wire [7:0] xl_param = (xl_op == OP_ENCAP) ? ENCAP_QUERY_PARAM : NO_PARAM;
	wire xl_check = (xl_op != OP_ENCAP); // Encapsulated requests carry no index to check.

	// ==========================================================
	// Retry timing.
	typedef enum logic [1:0] {SMAT_ST_IDLE, SMAT_ST_SEND, SMAT_ST_WAIT} smat_state_t;
	smat_state_t state; // Transaction phase.
	logic [1:0] tries; // Resends already made.
	logic [15:0] timer; // Timeout units left.
	logic [TICK_CNT_W-1:0] prescale; // Cycles within one timeout unit.
	wire tick = (prescale == TICK_LAST);
	// A zero setting still waits one unit so the line gets a chance to answer.
	wire [15:0] timer_load = (retry_timeout == 16'h0000) ? 16'h0001 : retry_timeout;
	wire expire = tick && (timer == 16'h0001);
	wire reply_good = reply_valid && reply.crc_ok && (reply.tag == query.tag)
		&& ((query.opcode != OP_ENCAP) || (reply.param == ENCAP_REPLY_PARAM));
	wire start = (state == SMAT_ST_IDLE) && head_valid;
	assign head_pop = start;

	// Free-running prescaler, restarted when a wait begins so each wait lasts whole units.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= '0;
		end else begin
			prescale <= (tick || (state == SMAT_ST_SEND)) ? '0 : TICK_CNT_W'(prescale + 1'b1);
		end
	end

	// ==========================================================
	// Transaction sequencer.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= SMAT_ST_IDLE;
			tries <= 2'h0;
			timer <= 16'h0000;
			query_valid <= 1'b0;
			query <= '0;
			done_valid <= 1'b0;
			done <= '0;
		end else begin
			done_valid <= 1'b0;
			case (state)
				SMAT_ST_IDLE: begin
					if (start) begin
						tries <= 2'h0;
						query <= '{xl_op, xl_addr, xl_count, head.mask, xl_param, head.tag};
						if (xl_check && !index_ok) begin
							done_valid <= 1'b1;
							done <= '{head.tag, 1'b1, 2'h0};
						end else begin
							query_valid <= 1'b1;
							state <= SMAT_ST_SEND;
						end
					end
				end
				SMAT_ST_SEND: begin
					// Query stands until the framer takes it.
					if (query_ready) begin
						query_valid <= 1'b0;
						timer <= timer_load;
						state <= SMAT_ST_WAIT;
					end
				end
				SMAT_ST_WAIT: begin
					if (reply_good) begin
						done_valid <= 1'b1;
						done <= '{query.tag, 1'b0, tries};
						state <= SMAT_ST_IDLE;
					end else if (expire && tries < MAX_RETRIES) begin
						tries <= 2'(tries + 1'b1);
						query_valid <= 1'b1;
						state <= SMAT_ST_SEND;
					end else if (expire) begin
						done_valid <= 1'b1;
						done <= '{query.tag, 1'b1, tries};
						state <= SMAT_ST_IDLE;
					end else if (tick) begin
						timer <= 16'(timer - 1'b1);
					end
				end
				default: begin
					state <= SMAT_ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Buffer ready and slave-side index.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			req_ready <= 1'b0;
			fill <= 5'h00;
			slave_index_valid <= 1'b0;
			slave_index <= 16'h0000;
		end else begin
			// Ready looks one cycle ahead, so a push taken with registered ready never overruns.
			fill <= next_fill;
			req_ready <= (next_fill != 5'(FIFO_DEPTH));
			slave_index_valid <= slave_valid;
			slave_index <= 16'(slave_addr + ZERO_OFFSET);
		end
	end

	// ==========================================================
	// Line enables.
	smat_driver u_driver (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.drv_mode(drv_mode),
		.cts(cts),
		.transmitting(transmitting),
		.tx_enable(tx_enable),
		.rx_enable(rx_enable),
		.opt_multidrop(opt_multidrop),
		.opt_full_duplex(opt_full_duplex)
	);

	// ==========================================================
	// Checks.
	sequence s_wait_expire_retry;
		(state == SMAT_ST_WAIT) && !reply_good && expire && (tries < MAX_RETRIES);
	endsequence
	sequence s_wait_expire_last;
		(state == SMAT_ST_WAIT) && !reply_good && expire && (tries == MAX_RETRIES);
	endsequence

	a_fixed_zero_offset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(port_mode != SMAT_PM_CONFIG) |-> (offset_eff == ZERO_OFFSET))
		else $error("Offset used outside configurable mode.");
	a_reg_addr_sum: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start && is_reg_op |=> query.address == 16'($past(head.index) + $past(offset_eff)))
		else $error("Register address is not index plus offset.");
	a_coil_addr_calc: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start && is_coil_op |=> query.address == 16'((($past(reg_sum) - 16'h0001) << 4) + 16'h0001))
		else $error("Coil start address wrong.");
	a_full_mask_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start && !is_config && head.kind == SMAT_REQ_MASKED && full_mask |=> query.opcode == OP_WRITE_REGS)
		else $error("Full-mask write not sent as opcode 16.");
	a_encap_param: assert property (@(posedge clk_sys) disable iff (!rst_n)
		query_valid && query.opcode == OP_ENCAP |-> query.param == ENCAP_QUERY_PARAM)
		else $error("Encapsulated query lacks parameter 01.");
	a_timeout_resend: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_wait_expire_retry |=> query_valid && $stable(query) && tries == 2'($past(tries) + 1'b1))
		else $error("Timeout did not resend the same query.");
	a_retry_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		query_valid && query_ready |-> tries <= MAX_RETRIES)
		else $error("More than two resends.");
	a_final_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_wait_expire_last |=> done_valid && done.error && state == SMAT_ST_IDLE)
		else $error("Final timeout returned no error.");
	a_index_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start && xl_check && !index_ok |=> done_valid && done.error && !query_valid)
		else $error("Out-of-span index was sent.");
	a_slave_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		slave_valid |=> slave_index_valid && slave_index == $past(slave_addr))
		else $error("Slave index altered by offset.");
	a_always_on_tx: assert property (@(posedge clk_sys) disable iff (!rst_n)
		drv_mode == SMAT_DRV_ALWAYS_ON |=> tx_enable && opt_full_duplex)
		else $error("Always-on driver released.");
	a_two_wire_rx: assert property (@(posedge clk_sys) disable iff (!rst_n)
		drv_mode == SMAT_DRV_TWO_WIRE && (transmitting || cts) |=> !rx_enable && opt_multidrop)
		else $error("Receiver open while transmitting.");
endmodule : smat_translator
`default_nettype wire

// ### bench/smat_slave_model.sv
// Behavioural serial slave behind the framer: takes queries, flags the line busy, answers by tag.
// Assumes the bench steers stall, mute and reply_delay as levels on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module smat_slave_model
	import smat_pkg::*;
(
	input wire logic clk_sys,
	input wire logic stall,
	input wire logic mute,
	input wire logic [7:0] reply_delay,
	input wire logic query_valid,
	output logic query_ready,
	input wire smat_query_t query,
	output logic reply_valid,
	output smat_reply_t reply,
	output logic transmitting
);
	// ==========================================================
	// State.
	smat_query_t held; // Query being answered.
	int wait_cnt = -1; // Cycles until the reply; -1 while silent.
	int tx_cnt = 0; // Cycles the query still occupies the line.

	assign transmitting = (tx_cnt > 0);

	initial begin
		query_ready = 1'b0;
		reply_valid = 1'b0;
		reply = '0;
	end

	// Ready is one cycle wide so the framer never takes a query twice.
	always @(posedge clk_sys) begin
		query_ready <= query_valid && !query_ready && !stall;
		reply_valid <= 1'b0;
		// Idle reply lines toggle so a stale value is never mistaken for an answer.
		reply <= ~reply;
		if (tx_cnt > 0)
			tx_cnt <= tx_cnt - 1;
		if (wait_cnt > 0)
			wait_cnt <= wait_cnt - 1;
		if (wait_cnt == 0) begin
			reply_valid <= 1'b1;
			reply <= '{tag: held.tag, param: (held.opcode == OP_ENCAP) ? ENCAP_REPLY_PARAM : NO_PARAM, crc_ok: 1'b1};
			wait_cnt <= -1;
		end
		if (query_valid && query_ready) begin
			held <= query;
			tx_cnt <= 4;
			wait_cnt <= mute ? -1 : int'(reply_delay);
		end
	end
endmodule : smat_slave_model
`default_nettype wire

// ### bench/tb_smat_translator.sv
// Self-checking bench of the serial master translator with a behavioural slave on the far side.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_smat_translator
	import smat_pkg::*;
;
	// ==========================================================
	// Signals.
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	smat_port_mode_t port_mode = SMAT_PM_FIXED;
	smat_drv_mode_t drv_mode = SMAT_DRV_TWO_WIRE;
	logic [7:0] cfg_read_opcode = OP_READ_HOLD;
	logic [7:0] cfg_write_opcode = OP_WRITE_REGS;
	logic [15:0] reg_offset = 16'h0000;
	logic [15:0] retry_timeout = 16'h0001;
	logic req_valid = 1'b0;
	smat_req_t req = '0;
	logic slave_valid = 1'b0;
	logic [15:0] slave_addr = 16'h0000;
	logic cts = 1'b0;
	logic stall = 1'b0;
	logic mute = 1'b0;
	logic [7:0] reply_delay = 8'h08;
	logic req_ready, query_valid, query_ready, reply_valid, done_valid, slave_index_valid;
	logic transmitting, tx_enable, rx_enable, opt_multidrop, opt_full_duplex, tx_seen;
	logic [15:0] slave_index;
	smat_query_t query;
	smat_reply_t reply;
	smat_done_t done;
	int num_errors = 0;
	int compares = 0;
	int nq = 0; // Queries taken by the slave.

	always #2 clk_sys = ~clk_sys;

	smat_translator DUT (.clk_sys(clk_sys), .resetn(resetn), .port_mode(port_mode), .drv_mode(drv_mode),
		.cfg_read_opcode(cfg_read_opcode), .cfg_write_opcode(cfg_write_opcode), .reg_offset(reg_offset),
		.retry_timeout(retry_timeout), .req_valid(req_valid), .req_ready(req_ready), .req(req),
		.query_valid(query_valid), .query_ready(query_ready), .query(query), .reply_valid(reply_valid),
		.reply(reply), .done_valid(done_valid), .done(done), .slave_valid(slave_valid),
		.slave_addr(slave_addr), .slave_index_valid(slave_index_valid), .slave_index(slave_index),
		.cts(cts), .transmitting(transmitting), .tx_enable(tx_enable), .rx_enable(rx_enable),
		.opt_multidrop(opt_multidrop), .opt_full_duplex(opt_full_duplex));

	smat_slave_model u_slave (.clk_sys(clk_sys), .stall(stall), .mute(mute), .reply_delay(reply_delay),
		.query_valid(query_valid), .query_ready(query_ready), .query(query), .reply_valid(reply_valid),
		.reply(reply), .transmitting(transmitting));

	// Counts handshakes and watches that the two-wire receiver stays off while the line is busy.
	always @(posedge clk_sys) begin
		if (query_valid === 1'b1 && query_ready === 1'b1) begin
			nq <= nq + 1;
		end
		tx_seen <= transmitting === 1'b1 && drv_mode == SMAT_DRV_TWO_WIRE;
		if (tx_seen === 1'b1 && rx_enable !== 1'b0) begin
			fail("receiver on while sending");
		end
	end

	// ==========================================================
	// Shared tasks.
	task automatic fail(input string what);
		num_errors++;
		$display("unexpected at %0t ns: %s", $time, what);
	endtask : fail

	task automatic check(input logic ok, input string what);
		compares++;
		if (ok !== 1'b1) begin
			fail(what);
		end
	endtask : check

	task automatic give_verdict();
		if (num_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	task automatic timed_out(input int n, input int lim);
		if (n >= lim) begin
			fail("wait ran out");
			give_verdict();
		end
	endtask : timed_out

	task automatic send(input smat_req_kind_t k, input logic [15:0] idx, input logic [7:0] tg);
		int n;
		req_valid <= 1'b1;
		req <= '{kind: k, index: idx, count: 8'h01, mask: FULL_MASK, tag: tg};
		for (n = 0; n < 100; n++) begin
			@(posedge clk_sys);
			if (req_ready === 1'b1) break;
		end
		req_valid <= 1'b0;
		timed_out(n, 100);
	endtask : send

	task automatic expect_done(input logic err, input logic [1:0] tries, input logic [7:0] tg);
		int n;
		for (n = 0; n < 2000; n++) begin
			@(posedge clk_sys);
			if (done_valid === 1'b1) break;
		end
		timed_out(n, 2000);
		check(done.tag === tg && done.error === err && done.retries === tries, "completion");
	endtask : expect_done

	// One request whose query is compared field by field, then completed cleanly.
	task automatic xfer(input smat_req_kind_t k, input logic [15:0] idx, input logic [7:0] tg,
		input logic [7:0] op, input logic [15:0] addr, input logic [15:0] cnt, input logic [7:0] prm);
		int n;
		send(k, idx, tg);
		for (n = 0; n < 1000; n++) begin
			@(posedge clk_sys);
			if (query_valid === 1'b1 && query_ready === 1'b1) break;
		end
		timed_out(n, 1000);
		check(query.opcode === op && query.param === prm && query.tag === tg && query.mask === FULL_MASK, "query opcode");
		if (op != OP_ENCAP) begin
			check(query.address === addr && query.count === cnt, "query address");
		end
		expect_done(1'b0, 2'h0, tg);
	endtask : xfer

	// ==========================================================
	// Scenarios.
	task automatic t_drv();
		for (int m = 0; m < 4; m++) begin
			for (int c = 0; c < 2; c++) begin
				drv_mode <= smat_drv_mode_t'(m);
				cts <= c[0];
				repeat (3) @(posedge clk_sys);
				check(tx_enable === (m == 0 ? 1'b1 : m == 3 ? 1'b0 : c[0]), "transmitter enable");
				check(rx_enable === (m == 2 ? !c[0] : 1'b1), "receiver enable");
				check(opt_multidrop === (m == 2) && opt_full_duplex === (m != 2), "options");
			end
		end
		drv_mode <= SMAT_DRV_TWO_WIRE;
		cts <= 1'b0;
	endtask : t_drv

	task automatic t_modes();
		reg_offset <= 16'h1234;
		for (int m = 0; m < 2; m++) begin
			port_mode <= smat_port_mode_t'(m);
			xfer(SMAT_REQ_READ, 16'd5, 8'h01, OP_READ_HOLD, 16'd5, 16'h0001, NO_PARAM);
			xfer(SMAT_REQ_WRITE, 16'd6, 8'h02, OP_WRITE_REGS, 16'd6, 16'h0001, NO_PARAM);
			xfer(SMAT_REQ_MASKED, 16'd7, 8'h03, OP_WRITE_REGS, 16'd7, 16'h0001, NO_PARAM);
			xfer(SMAT_REQ_OTHER, 16'd8, 8'h04, OP_ENCAP, 16'd0, 16'd0, ENCAP_QUERY_PARAM);
		end
	endtask : t_modes

	task automatic t_config();
		port_mode <= SMAT_PM_CONFIG;
		reg_offset <= 16'd500;
		reply_delay <= 8'd90;
		cfg_read_opcode <= OP_READ_INPUT;
		cfg_write_opcode <= OP_WRITE_REG;
		xfer(SMAT_REQ_READ, 16'd121, 8'h11, OP_READ_INPUT, 16'd621, 16'h0001, NO_PARAM);
		xfer(SMAT_REQ_WRITE, 16'd5175, 8'h12, OP_WRITE_REG, 16'd5675, 16'h0001, NO_PARAM);
		cfg_read_opcode <= OP_READ_COILS;
		xfer(SMAT_REQ_READ, 16'd3, 8'h13, OP_READ_COILS, 16'd8033, 16'h0010, NO_PARAM);
		reg_offset <= 16'h0000;
		cfg_write_opcode <= OP_WRITE_COILS;
		xfer(SMAT_REQ_WRITE, 16'd1, 8'h14, OP_WRITE_COILS, 16'd1, 16'h0010, NO_PARAM);
		cfg_read_opcode <= OP_READ_HOLD;
		reg_offset <= 16'hffff;
		xfer(SMAT_REQ_READ, 16'd2, 8'h15, OP_READ_HOLD, 16'd1, 16'h0001, NO_PARAM);
		reply_delay <= 8'h08;
		port_mode <= SMAT_PM_FIXED;
		reg_offset <= 16'h0000;
	endtask : t_config

	task automatic t_range();
		int n0;
		xfer(SMAT_REQ_READ, 16'd8192, 8'h21, OP_READ_HOLD, 16'd8192, 16'h0001, NO_PARAM);
		for (int i = 0; i < 2; i++) begin
			n0 = nq;
			send(SMAT_REQ_READ, (i == 1) ? 16'd8193 : 16'd0, 8'h22);
			expect_done(1'b1, 2'h0, 8'h22);
			check(nq == n0, "query for bad index");
		end
	endtask : t_range

	task automatic t_retry();
		int n0;
		int n;
		time t0;
		mute <= 1'b1;
		n0 = nq;
		t0 = $time;
		send(SMAT_REQ_READ, 16'd9, 8'h31);
		for (n = 0; n < 2000 && nq < n0 + 2; n++) begin
			@(posedge clk_sys);
		end
		timed_out(n, 2000);
		mute <= 1'b0;
		expect_done(1'b0, 2'h2, 8'h31);
		check(nq == n0 + 3 && $time - t0 >= 2000, "resend count or spacing");
		mute <= 1'b1;
		n0 = nq;
		send(SMAT_REQ_WRITE, 16'd9, 8'h32);
		expect_done(1'b1, 2'h2, 8'h32);
		repeat (300) @(posedge clk_sys);
		check(nq == n0 + 3, "fourth transmission");
		mute <= 1'b0;
	endtask : t_retry

	task automatic t_slave();
		port_mode <= SMAT_PM_CONFIG;
		reg_offset <= 16'd500;
		slave_valid <= 1'b1;
		slave_addr <= 16'h0123;
		@(posedge clk_sys);
		slave_valid <= 1'b0;
		@(posedge clk_sys);
		check(slave_index_valid === 1'b1 && slave_index === 16'h0123, "slave index");
		port_mode <= SMAT_PM_FIXED;
		reg_offset <= 16'h0000;
	endtask : t_slave

	// Fills the buffer against a stalled framer, then drains it in order.
	task automatic t_fifo();
		int n;
		stall <= 1'b1;
		for (n = 0; n < 40; n++) begin
			repeat (2) @(posedge clk_sys);
			if (req_ready !== 1'b1) break;
			req_valid <= 1'b1;
			req <= '{kind: SMAT_REQ_READ, index: 16'd10, count: 8'h01, mask: FULL_MASK, tag: 8'h40 + 8'(n)};
			@(posedge clk_sys);
			req_valid <= 1'b0;
		end
		check(n >= 16 && n <= 17, "buffer depth");
		stall <= 1'b0;
		for (int i = 0; i < n; i++) begin
			expect_done(1'b0, 2'h0, 8'h40 + 8'(i));
		end
	endtask : t_fifo

	initial begin
		int n;
		repeat (12) @(posedge clk_sys);
		check(req_ready === 1'b0 && tx_enable === 1'b0 && rx_enable === 1'b0, "outputs in reset");
		resetn <= 1'b1;
		for (n = 0; n < 10; n++) begin
			@(posedge clk_sys);
			if (req_ready === 1'b1) break;
		end
		timed_out(n, 10);
		t_drv();
		t_modes();
		t_config();
		t_range();
		t_retry();
		t_slave();
		t_fifo();
		give_verdict();
	end
endmodule : tb_smat_translator
`default_nettype wire
